/* logic/lps_defs.vh */
// constants for the link aggregation port select block
`ifndef LPS_DEFS_VH
`define LPS_DEFS_VH

// port and table sizes
`define LPS_NPORTS        12
`define LPS_PW            4
`define LPS_CODE_W        4
`define LPS_DEST_W        6
`define LPS_NTBL          92
`define LPS_AGGR_BASE     7'h40
`define LPS_SRC_BASE      7'h50

// register word indices, byte address is four times the index
`define LPS_WIDX_W        10
`define LPS_CFG_WIDX      10'h000
`define LPS_STAT_WIDX     10'h001
`define LPS_LPORT_WIDX    10'h040
`define LPS_LPORT_END     10'h04c
`define LPS_TBL_WIDX      10'h100
`define LPS_TBL_END       10'h15c

// hash_select_config fields
`define LPS_CFG_W         7
`define LPS_CFG_RST       7'h00
`define LPS_B_SMAC        0
`define LPS_B_DMAC        1
`define LPS_B_V4ADDR      2
`define LPS_B_V4L4        3
`define LPS_B_V6L4        4
`define LPS_B_V6FLOW      5
`define LPS_B_RND         6

// status fields
`define LPS_CNT_W         16
`define LPS_STAT_PAD_W    12

// reset values
`define LPS_TBL_RST       12'h000
`define LPS_LPORT_RST     4'h0
`define LPS_CODE_RST      4'h0
`define LPS_CNT_RST       16'h0000
`define LPS_DATA_RST      32'h00000000
`define LPS_LFSR_SEED     16'hace1
`define LPS_LFSR_TAPS     16'hb400

// ahb
`define LPS_HTRANS_NONSEQ_BIT 1

`endif

/* logic/lps_fold.v */
// xor fold of a header field into a four bit code
`timescale 1ns/100ps
`default_nettype none
`include "lps_defs.vh"
module lps_fold #(
  parameter W = 48
) (
  input  wire [W-1:0]           din,
  input  wire                   en,
  output reg  [`LPS_CODE_W-1:0] dout
);
  integer i;
  always @* begin
    dout = {`LPS_CODE_W{1'b0}};
    for (i = 0; i < W / `LPS_CODE_W; i = i + 1) begin
      dout = dout ^ din[i*`LPS_CODE_W +: `LPS_CODE_W];
    end
    if (!en) begin
      dout = {`LPS_CODE_W{1'b0}}; // RL16
    end
  end
endmodule
`default_nettype wire

/* logic/lps_lfsr.v */
// free running galois lfsr for random codes
`timescale 1ns/100ps
`default_nettype none
`include "lps_defs.vh"
module lps_lfsr (
  input  wire        clk,
  input  wire        arst_n,
  input  wire        ce,
  output reg  [15:0] q_r
);
  wire [15:0] q_nxt;
  assign q_nxt = q_r[0] ? ((q_r >> 1) ^ `LPS_LFSR_TAPS) : (q_r >> 1);
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      q_r <= `LPS_LFSR_SEED;
    end else if (ce) begin
      q_r <= q_nxt;
    end
  end
endmodule
`default_nettype wire

/* logic/lps_port_select.v */
// link aggregation egress port selection with ahb-lite register slave
`timescale 1ns/100ps
`default_nettype none
`include "lps_defs.vh"
// Behaviour
// (RL1) every frame gets a 4-bit aggregation code that picks the one group member it leaves on.
// (RL2) the code depends only on frame fields, so one flow always takes one member port.
// (RL3) smac, dmac, v4 addresses, v4 ports, v6 ports and v6 flow label each count only when enabled.
// (RL4) with the random enable set a random code replaces the hash, software should leave it at 0.
// (RL5) software sets the field enables once for all ports, best with all of them at 1.
// (RL6) groups hold up to 16 members and any number of groups fit the available ports.
// (RL7) software never puts one port into two groups.
// (RL8) software gives all members of a group the same link speed.
// (RL9) each port holds a logical port number that software sets alike for all group members.
// (RL10) 64 destination masks sit at indices 0-63, each member's mask covering the whole group.
// (RL11) source masks per ingress port sit at indices 80-91 and exclude the port's own group.
// (RL12) 16 aggregation masks at indices 64-79 are picked by the code, one member per group each.
// (RL13) a port cleared in all sixteen aggregation masks receives no frames.
// (RL14) an all-zero source mask stops any forwarding of frames from that port.
// (RL15) egress set is destination mask and aggregation mask and source mask.
// (RL16) enabled fields fold into the code by fixed xor, disabled fields give zero.
module lps_port_select (
  input  wire                     CLK,
  input  wire                     ARST_N,
  input  wire                     CE,
  input  wire                     HSEL,
  input  wire [31:0]              HADDR,
  input  wire [1:0]               HTRANS,
  input  wire                     HWRITE,
  input  wire [2:0]               HSIZE,
  input  wire [31:0]              HWDATA,
  input  wire                     HREADY,
  output reg  [31:0]              HRDATA,
  output reg                      HREADYOUT,
  output reg                      HRESP,
  input  wire                     FRM_VALID,
  input  wire [`LPS_PW-1:0]       FRM_SRC_PORT,
  input  wire [`LPS_DEST_W-1:0]   FRM_DEST_IDX,
  input  wire [47:0]              FRM_SMAC,
  input  wire [47:0]              FRM_DMAC,
  input  wire                     FRM_IS_V4,
  input  wire                     FRM_IS_V6,
  input  wire                     FRM_HAS_L4,
  input  wire [31:0]              FRM_SIP,
  input  wire [31:0]              FRM_DIP,
  input  wire [15:0]              FRM_SPORT,
  input  wire [15:0]              FRM_DPORT,
  input  wire [19:0]              FRM_FLOW_LBL,
  output reg                      EGR_VALID,
  output reg  [`LPS_NPORTS-1:0]   EGR_PORTS,
  output reg  [`LPS_CODE_W-1:0]   EGR_CODE,
  output reg  [`LPS_PW-1:0]       EGR_LPORT
);
  // configuration and tables
  reg  [`LPS_CFG_W-1:0]   hash_select_config_r;
  reg  [`LPS_NPORTS-1:0]  port_group_mask_table_r [0:`LPS_NTBL-1];
  reg  [`LPS_PW-1:0]      logical_port_number_r [0:`LPS_NPORTS-1];
  reg  [`LPS_CNT_W-1:0]   frm_cnt_r;
  reg  [`LPS_CODE_W-1:0]  last_code_r;
  // bus state
  reg                     wr_pend_r;
  reg                     rd_pend_r;
  reg  [`LPS_WIDX_W-1:0]  acc_idx_r;
  reg  [31:0]             rd_val;
  integer                 i;

  wire [15:0]             rnd_q;
  wire [`LPS_CODE_W-1:0]  c_smac;
  wire [`LPS_CODE_W-1:0]  c_dmac;
  wire [`LPS_CODE_W-1:0]  c_v4a;
  wire [`LPS_CODE_W-1:0]  c_v4p;
  wire [`LPS_CODE_W-1:0]  c_v6p;
  wire [`LPS_CODE_W-1:0]  c_v6f;
  wire [`LPS_CODE_W-1:0]  hash_code;
  wire [`LPS_CODE_W-1:0]  aggregation_code;
  wire                    src_ok;
  wire [6:0]              dest_i;
  wire [6:0]              aggr_i;
  wire [6:0]              src_i;
  wire [`LPS_NPORTS-1:0]  egr_nxt;
  wire [`LPS_WIDX_W-1:0]  tbl_off;
  wire [`LPS_WIDX_W-1:0]  lp_off;
  wire                    addr_ok;

  lps_lfsr u_rnd (
    .clk    (CLK),
    .arst_n (ARST_N),
    .ce     (CE),
    .q_r    (rnd_q)
  );

  lps_fold #(.W(48)) u_smac ( // RL3
    .din  (FRM_SMAC),
    .en   (hash_select_config_r[`LPS_B_SMAC]),
    .dout (c_smac)
  );
  lps_fold #(.W(48)) u_dmac ( // RL3
    .din  (FRM_DMAC),
    .en   (hash_select_config_r[`LPS_B_DMAC]),
    .dout (c_dmac)
  );
  lps_fold #(.W(64)) u_v4a ( // RL3
    .din  ({FRM_SIP, FRM_DIP}),
    .en   (hash_select_config_r[`LPS_B_V4ADDR] & FRM_IS_V4),
    .dout (c_v4a)
  );
  lps_fold #(.W(32)) u_v4p ( // RL3
    .din  ({FRM_SPORT, FRM_DPORT}),
    .en   (hash_select_config_r[`LPS_B_V4L4] & FRM_IS_V4 & FRM_HAS_L4),
    .dout (c_v4p)
  );
  lps_fold #(.W(32)) u_v6p ( // RL3
    .din  ({FRM_SPORT, FRM_DPORT}),
    .en   (hash_select_config_r[`LPS_B_V6L4] & FRM_IS_V6 & FRM_HAS_L4),
    .dout (c_v6p)
  );
  lps_fold #(.W(20)) u_v6f ( // RL3
    .din  (FRM_FLOW_LBL),
    .en   (hash_select_config_r[`LPS_B_V6FLOW] & FRM_IS_V6),
    .dout (c_v6f)
  );

  assign hash_code = c_smac ^ c_dmac ^ c_v4a ^ c_v4p ^ c_v6p ^ c_v6f; // RL16 RL2
  assign aggregation_code = hash_select_config_r[`LPS_B_RND] ?
                            rnd_q[`LPS_CODE_W-1:0] : hash_code; // RL4 RL1

  // table lookup
  assign src_ok  = (FRM_SRC_PORT < `LPS_NPORTS);
  assign dest_i  = {1'b0, FRM_DEST_IDX}; // RL10
  assign aggr_i  = `LPS_AGGR_BASE + {3'h0, aggregation_code}; // RL12
  assign src_i   = `LPS_SRC_BASE + {3'h0, FRM_SRC_PORT}; // RL11
  assign egr_nxt = src_ok ? (port_group_mask_table_r[dest_i] &
                             port_group_mask_table_r[aggr_i] &
                             port_group_mask_table_r[src_i]) :
                            {`LPS_NPORTS{1'b0}}; // RL15 RL13 RL14 RL6

  // register decode
  assign tbl_off = acc_idx_r - `LPS_TBL_WIDX;
  assign lp_off  = acc_idx_r - `LPS_LPORT_WIDX;
  assign addr_ok = 1'b1;

  always @* begin
    rd_val = `LPS_DATA_RST;
    if (acc_idx_r == `LPS_CFG_WIDX) begin
      rd_val[`LPS_CFG_W-1:0] = hash_select_config_r;
    end else if (acc_idx_r == `LPS_STAT_WIDX) begin
      rd_val = {frm_cnt_r, {`LPS_STAT_PAD_W{1'b0}}, last_code_r};
    end else if (acc_idx_r >= `LPS_LPORT_WIDX && acc_idx_r < `LPS_LPORT_END) begin
      rd_val[`LPS_PW-1:0] = logical_port_number_r[lp_off[3:0]];
    end else if (acc_idx_r >= `LPS_TBL_WIDX && acc_idx_r < `LPS_TBL_END) begin
      rd_val[`LPS_NPORTS-1:0] = port_group_mask_table_r[tbl_off[6:0]];
    end
  end

  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      hash_select_config_r <= `LPS_CFG_RST;
      for (i = 0; i < `LPS_NTBL; i = i + 1) begin
        port_group_mask_table_r[i] <= `LPS_TBL_RST;
      end
      for (i = 0; i < `LPS_NPORTS; i = i + 1) begin
        logical_port_number_r[i] <= `LPS_LPORT_RST;
      end
      frm_cnt_r   <= `LPS_CNT_RST;
      last_code_r <= `LPS_CODE_RST;
      wr_pend_r   <= 1'b0;
      rd_pend_r   <= 1'b0;
      acc_idx_r   <= {`LPS_WIDX_W{1'b0}};
      HRDATA      <= `LPS_DATA_RST;
      HREADYOUT   <= 1'b1;
      HRESP       <= 1'b0;
      EGR_VALID   <= 1'b0;
      EGR_PORTS   <= {`LPS_NPORTS{1'b0}};
      EGR_CODE    <= `LPS_CODE_RST;
      EGR_LPORT   <= `LPS_LPORT_RST;
    end else if (CE) begin
      // write data phase
      if (wr_pend_r) begin
        wr_pend_r <= 1'b0;
        if (acc_idx_r == `LPS_CFG_WIDX) begin
          hash_select_config_r <= HWDATA[`LPS_CFG_W-1:0]; // RL3 RL4
        end else if (acc_idx_r >= `LPS_LPORT_WIDX && acc_idx_r < `LPS_LPORT_END) begin
          logical_port_number_r[lp_off[3:0]] <= HWDATA[`LPS_PW-1:0]; // RL9
        end else if (acc_idx_r >= `LPS_TBL_WIDX && acc_idx_r < `LPS_TBL_END) begin
          port_group_mask_table_r[tbl_off[6:0]] <= HWDATA[`LPS_NPORTS-1:0]; // RL10 RL11 RL12
        end
      end
      // read: one wait cycle then data
      if (rd_pend_r) begin
        rd_pend_r <= 1'b0;
        HRDATA    <= rd_val;
        HREADYOUT <= 1'b1;
      end
      // address phase
      if (HSEL && HREADY && HTRANS[`LPS_HTRANS_NONSEQ_BIT] && addr_ok) begin
        acc_idx_r <= HADDR[`LPS_WIDX_W+1:2];
        if (HWRITE) begin
          wr_pend_r <= 1'b1;
        end else begin
          rd_pend_r <= 1'b1;
          HREADYOUT <= 1'b0;
        end
      end
      // frame path
      EGR_VALID <= FRM_VALID;
      if (FRM_VALID) begin
        EGR_PORTS   <= egr_nxt; // RL15 RL1
        EGR_CODE    <= aggregation_code; // RL1
        EGR_LPORT   <= src_ok ? logical_port_number_r[FRM_SRC_PORT] : `LPS_LPORT_RST; // RL9
        last_code_r <= aggregation_code;
        frm_cnt_r   <= frm_cnt_r + 16'h0001;
      end
    end
  end
endmodule
`default_nettype wire

/* logic/lps_unused_placeholder_none.v */
// intentionally empty companion file
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

/* testbench/lps_peer.sv */
// peer switch model counting frames that reach the aggregated link
`timescale 1ns/100ps
`default_nettype none
module lps_peer (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        valid,
  input  wire logic [11:0] ports,
  input  wire logic [11:0] members,
  output var  logic [15:0] hits
);
  // a frame for the link counts only if exactly one member gets it
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) hits <= 16'h0000;
    else if (valid && $countones(ports & members) == 1) hits <= hits + 16'h0001;
  end
endmodule
`default_nettype wire

/* testbench/lps_port_select_sva.sv */
// assertions on the port select block ports
`timescale 1ns/100ps
`default_nettype none
module lps_port_select_sva (
  input wire logic        CLK,
  input wire logic        ARST_N,
  input wire logic        CE,
  input wire logic        HSEL,
  input wire logic [1:0]  HTRANS,
  input wire logic        HWRITE,
  input wire logic        HREADY,
  input wire logic [31:0] HRDATA,
  input wire logic        HREADYOUT,
  input wire logic        HRESP,
  input wire logic        FRM_VALID,
  input wire logic [3:0]  FRM_SRC_PORT,
  input wire logic        EGR_VALID,
  input wire logic [11:0] EGR_PORTS,
  input wire logic [3:0]  EGR_CODE,
  input wire logic [3:0]  EGR_LPORT
);
  wire acc = CE && HSEL && HREADY && HTRANS[1];
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  a_egr_latency: assert property (FRM_VALID && CE |=> EGR_VALID)
    else $error("no egress pulse");
  a_egr_quiet: assert property (CE && !FRM_VALID |=> !EGR_VALID)
    else $error("egress pulse without frame");
  a_src_empty: assert property (CE && FRM_VALID && FRM_SRC_PORT > 4'hb
    |=> EGR_PORTS == 12'h000 && EGR_LPORT == 4'h0) else $error("unknown port forwarded");
  a_egr_hold: assert property (!EGR_VALID
    |-> $stable(EGR_PORTS) && $stable(EGR_CODE)) else $error("egress data moved");
  a_read_wait: assert property (acc && !HWRITE |=> !HREADYOUT ##1 HREADYOUT)
    else $error("read wait wrong");
  a_write_nowait: assert property (acc && HWRITE |=> HREADYOUT) else $error("write stalled");
  a_resp_okay: assert property (HRESP == 1'b0) else $error("bad response");
  a_rdata_hold: assert property ($changed(HRDATA) |-> !$past(HREADYOUT))
    else $error("read data moved");
  c_burst: cover property (FRM_VALID ##1 FRM_VALID);
  c_read: cover property (acc && !HWRITE);
  c_src_bad: cover property (FRM_VALID && FRM_SRC_PORT > 4'hb);
endmodule
bind lps_port_select lps_port_select_sva lps_port_select_sva_inst (.CLK, .ARST_N, .CE,
  .HSEL, .HTRANS, .HWRITE, .HREADY, .HRDATA, .HREADYOUT, .HRESP, .FRM_VALID,
  .FRM_SRC_PORT, .EGR_VALID, .EGR_PORTS, .EGR_CODE, .EGR_LPORT);
`default_nettype wire

/* testbench/lps_port_select_test.sv */
// self-checking bench for the port select block
`timescale 1ns/100ps
`default_nettype none
module lps_port_select_test;
  localparam logic [11:0] GRP = 12'h033;
  logic CLK, ARST_N, HSEL, HWRITE, HREADYOUT, HRESP, FRM_VALID, EGR_VALID;
  logic FRM_IS_V4, FRM_IS_V6, FRM_HAS_L4;
  logic [1:0] HTRANS;
  logic [2:0] HSIZE;
  logic [31:0] HADDR, HWDATA, HRDATA, FRM_SIP, FRM_DIP, seed, rdv;
  logic [3:0] FRM_SRC_PORT, EGR_CODE, EGR_LPORT, lastc, lp[0:11];
  logic [5:0] FRM_DEST_IDX;
  logic [47:0] FRM_SMAC, FRM_DMAC;
  logic [15:0] FRM_SPORT, FRM_DPORT, hits, nhit, nfr;
  logic [19:0] FRM_FLOW_LBL;
  logic [11:0] EGR_PORTS, tbl[0:91];
  logic [6:0] cfg;
  logic [15:0] rq;
  int error_cnt, n_checks;
  lps_port_select lps_port_select_inst (.CLK, .ARST_N, .CE(1'b1), .HSEL, .HADDR, .HTRANS,
    .HWRITE, .HSIZE, .HWDATA, .HREADY(HREADYOUT), .HRDATA, .HREADYOUT, .HRESP, .FRM_VALID,
    .FRM_SRC_PORT, .FRM_DEST_IDX, .FRM_SMAC, .FRM_DMAC, .FRM_IS_V4, .FRM_IS_V6, .FRM_HAS_L4,
    .FRM_SIP, .FRM_DIP, .FRM_SPORT, .FRM_DPORT, .FRM_FLOW_LBL, .EGR_VALID, .EGR_PORTS,
    .EGR_CODE, .EGR_LPORT);
  lps_peer lps_peer_inst (.clk(CLK), .arst_n(ARST_N), .valid(EGR_VALID), .ports(EGR_PORTS),
    .members(GRP), .hits);
  always #5 CLK = ~CLK;
  // reference random source, steps every cycle like the block's own
  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) rq <= 16'hace1;
    else rq <= rq[0] ? ((rq >> 1) ^ 16'hb400) : (rq >> 1);
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [3:0] fx(input logic [63:0] v);
    logic [3:0] h;
    h = 4'h0;
    for (int j = 0; j < 16; j++) h ^= v[4*j +: 4];
    return h;
  endfunction
  function automatic logic [3:0] ecode();
    logic [3:0] h;
    h = 4'h0;
    if (cfg[0]) h ^= fx(FRM_SMAC);
    if (cfg[1]) h ^= fx(FRM_DMAC);
    if (cfg[2] && FRM_IS_V4) h ^= fx({FRM_SIP, FRM_DIP});
    if (cfg[3] && FRM_IS_V4 && FRM_HAS_L4) h ^= fx({FRM_SPORT, FRM_DPORT});
    if (cfg[4] && FRM_IS_V6 && FRM_HAS_L4) h ^= fx({FRM_SPORT, FRM_DPORT});
    if (cfg[5] && FRM_IS_V6) h ^= fx(FRM_FLOW_LBL);
    return h;
  endfunction
  task chk(input string nm, input logic [31:0] s, e);
    n_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  task finish_test();
    if (error_cnt == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task ahb(input logic w, input logic [31:0] a, d);
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HWRITE <= w;
    HADDR <= a;
    do @(posedge CLK); while (HREADYOUT !== 1'b1);
    HSEL <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= d;
    do @(posedge CLK); while (HREADYOUT !== 1'b1);
    rdv = HRDATA;
  endtask
  task wt(input logic [6:0] i, input logic [11:0] v);
    tbl[i] = v;
    ahb(1'b1, 32'h400 + {23'h0, i, 2'h0}, {20'h0, v});
  endtask
  task run(input int n);
    logic pend;
    logic [11:0] ep;
    logic [3:0] ec, el, c;
    logic [31:0] r;
    pend = 1'b0;
    for (int k = 0; k < n + 2; k++) begin
      @(posedge CLK);
      chk("egress valid", EGR_VALID, pend);
      if (pend) begin
        c = ec;
        chk("code", EGR_CODE, c);
        chk("ports", EGR_PORTS, ep & tbl[64 + c]);
        chk("lport", EGR_LPORT, el);
        if (|(ep & tbl[64 + c] & GRP)) nhit++;
        lastc = c;
        nfr++;
      end
      pend = FRM_VALID;
      ec = cfg[6] ? rq[3:0] : ecode();
      ep = FRM_SRC_PORT < 12 ? tbl[FRM_DEST_IDX] & tbl[80 + FRM_SRC_PORT] : 12'h000;
      el = FRM_SRC_PORT < 12 ? lp[FRM_SRC_PORT] : 4'h0;
      r = xs();
      FRM_VALID <= k < n && r[1:0] != 2'h0;
      FRM_SRC_PORT <= r[5:2];
      FRM_DEST_IDX <= r[11:6];
      FRM_IS_V4 <= r[12];
      FRM_IS_V6 <= !r[12];
      FRM_HAS_L4 <= r[13];
      FRM_SMAC <= {r[31:16], xs()};
      FRM_DMAC <= {r[15:0], xs()};
      FRM_SIP <= xs();
      FRM_DIP <= xs();
      {FRM_SPORT, FRM_DPORT} <= xs();
      r = xs();
      FRM_FLOW_LBL <= r[19:0];
    end
  endtask
  initial begin
    repeat (20000) @(posedge CLK);
    error_cnt++;
    finish_test();
  end
  initial begin
    {CLK, ARST_N, HSEL, HWRITE, HTRANS, HADDR, HWDATA, FRM_VALID, cfg} = '0;
    {FRM_IS_V4, FRM_IS_V6, FRM_HAS_L4, FRM_SRC_PORT, FRM_DEST_IDX, FRM_SMAC, FRM_DMAC} = '0;
    {FRM_SIP, FRM_DIP, FRM_SPORT, FRM_DPORT, FRM_FLOW_LBL, nhit, nfr} = '0;
    HSIZE = 3'h2;
    seed = 32'd41;
    repeat (8) @(posedge CLK);
    ARST_N <= 1'b1;
    @(posedge CLK);
    ahb(1'b0, 32'h400, 32'h0);
    chk("table reset", rdv, 32'h0);
    for (logic [3:0] p = 0; p < 12; p++) begin
      lp[p] = GRP[p] ? 4'h0 : p;
      ahb(1'b1, 32'h100 + {26'h0, p, 2'h0}, {28'h0, lp[p]});
    end
    for (logic [6:0] i = 0; i < 92; i++) begin
      wt(i, i < 64 ? (GRP[i % 12] ? GRP : 12'h001 << (i % 12))
        : i < 80 ? ~GRP | 12'h001 << ({1'b0, i[1:0]} + {1'b0, i[1], 1'b0})
        : GRP[i - 80] ? ~GRP : ~(12'h001 << (i - 80)));
    end
    for (int b = 0; b < 10; b++) begin
      cfg = b < 7 ? 7'h01 << b : b == 7 ? 7'h00 : b == 8 ? 7'h1f : 7'h3f;
      ahb(1'b1, 32'h0, {25'h0, cfg});
      run(40);
    end
    for (logic [6:0] i = 64; i < 80; i++) wt(i, tbl[i] & 12'hfdf);
    wt(7'd82, 12'h000);
    run(120);
    ahb(1'b0, 32'h518, 32'h0);
    chk("aggr mask", rdv, {20'h0, tbl[70]});
    ahb(1'b0, 32'h10c, 32'h0);
    chk("lport reg", rdv, 32'h3);
    ahb(1'b0, 32'h8, 32'h0);
    chk("unmapped", rdv, 32'h0);
    ahb(1'b0, 32'h4, 32'h0);
    chk("status", rdv, {nfr, 12'h000, lastc});
    chk("link hits", hits, nhit);
    finish_test();
  end
endmodule
`default_nettype wire
